/* File: rtl/cal_clock.sv */
// Purpose: BCD calendar clock with halt, load and half-minute rounding
// Assumes: cassette_present arrives from a pin; words written one at a time
// Notes: time words only accept writes while the clock is halted
`timescale 1ns/1ps
module cal_clock
#(
    parameter int unsigned TICK_CYCLES = cal_clock_pkg::TICK_CYCLES
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic cassette_present,
    input wire logic wr_en,
    input wire cal_clock_pkg::word_sel_t wr_sel,
    input wire logic [15:0] wr_data,
    output logic [15:0] hour_minute_quick_word,
    output logic [15:0] minute_second_word,
    output logic [15:0] date_hour_word,
    output logic [15:0] year_month_word,
    output logic [15:0] weekday_control_word,
    output logic time_valid
);

    logic present_meta_ff;
    logic present_ff;
    logic [31:0] div_ff;
    logic [31:0] nxt_div;
    logic tick;
    cal_clock_pkg::cal_time_t time_ff;
    cal_clock_pkg::cal_time_t nxt_time;
    cal_clock_pkg::cal_ctrl_t ctrl_ff;
    cal_clock_pkg::cal_ctrl_t nxt_ctrl;
    logic valid_ff;
    logic [15:0] quick_ff;
    logic running;
    logic round_up;
    logic [7:0] days_in_month;
    logic leap;
    logic c_sec;
    logic c_min;
    logic c_hour;
    logic c_date;
    logic c_month;
    logic [7:0] s_sec;
    logic [7:0] s_min;
    logic [7:0] s_hour;
    logic [7:0] s_date;
    logic [7:0] s_month;
    logic [7:0] s_year;
    logic [7:0] s_wday;

    // two-flop synchroniser for the cassette detect pin
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            present_meta_ff <= 1'b0;
            present_ff <= 1'b0;
        end
        else
        begin
            present_meta_ff <= cassette_present;
            present_ff <= present_meta_ff;
        end
    end

    assign running = present_ff && !ctrl_ff.halt;
    assign round_up = ctrl_ff.round && (time_ff.second >= cal_clock_pkg::HALF_MIN);

    // one-second divider; restarts on load so counting begins at a whole second
    always_comb
    begin
        nxt_div = div_ff;
        tick = 1'b0;
        if (!running || ctrl_ff.load)
        begin
            nxt_div = '0;
        end
        else if (div_ff >= 32'(TICK_CYCLES - 1))
        begin
            nxt_div = '0;
            tick = 1'b1;
        end
        else
        begin
            nxt_div = div_ff + 32'h1;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            div_ff <= '0;
        else
            div_ff <= nxt_div;
    end

    // leap year when the two-digit year is a multiple of four
    always_comb
    begin
        leap = time_ff.year[4] ? (time_ff.year[3:0] == 4'h2 || time_ff.year[3:0] == 4'h6)
                               : (time_ff.year[3:0] == 4'h0 || time_ff.year[3:0] == 4'h4
                                  || time_ff.year[3:0] == 4'h8);
        case (time_ff.month)
            cal_clock_pkg::FEB: days_in_month = leap ? cal_clock_pkg::DAYS_29
                                                     : cal_clock_pkg::DAYS_28;
            8'h04, 8'h06, 8'h09, 8'h11: days_in_month = cal_clock_pkg::DAYS_30;
            default: days_in_month = cal_clock_pkg::DAYS_31;
        endcase
    end

    // carry chain from seconds up to year, weekday on midnight
    bcd_pair_step u_sec (.value(time_ff.second), .inc(tick), .lo(cal_clock_pkg::ZERO_BCD),
        .hi(cal_clock_pkg::SEC_MAX), .nxt_value(s_sec), .carry(c_sec));
    bcd_pair_step u_min (.value(time_ff.minute), .inc(c_sec || round_up),
        .lo(cal_clock_pkg::ZERO_BCD), .hi(cal_clock_pkg::MIN_MAX),
        .nxt_value(s_min), .carry(c_min));
    bcd_pair_step u_hour (.value(time_ff.hour), .inc(c_min), .lo(cal_clock_pkg::ZERO_BCD),
        .hi(cal_clock_pkg::HOUR_MAX), .nxt_value(s_hour), .carry(c_hour));
    bcd_pair_step u_date (.value(time_ff.date), .inc(c_hour), .lo(cal_clock_pkg::ONE_BCD),
        .hi(days_in_month), .nxt_value(s_date), .carry(c_date));
    bcd_pair_step u_month (.value(time_ff.month), .inc(c_date), .lo(cal_clock_pkg::ONE_BCD),
        .hi(cal_clock_pkg::MONTH_MAX), .nxt_value(s_month), .carry(c_month));
    bcd_pair_step u_year (.value(time_ff.year), .inc(c_month), .lo(cal_clock_pkg::ZERO_BCD),
        .hi(cal_clock_pkg::YEAR_MAX), .nxt_value(s_year), .carry());
    bcd_pair_step u_wday (.value(time_ff.weekday), .inc(c_hour), .lo(cal_clock_pkg::ZERO_BCD),
        .hi(cal_clock_pkg::WDAY_MAX), .nxt_value(s_wday), .carry());

    // time and control next state: counting, rounding, writes, cassette loss
    always_comb
    begin
        nxt_time = time_ff;
        nxt_ctrl = ctrl_ff;
        nxt_time.second = s_sec;
        nxt_time.minute = s_min;
        nxt_time.hour = s_hour;
        nxt_time.date = s_date;
        nxt_time.month = s_month;
        nxt_time.year = s_year;
        nxt_time.weekday = s_wday;
        if (ctrl_ff.round)
        begin
            nxt_time.second = cal_clock_pkg::ZERO_BCD;
            nxt_ctrl.round = 1'b0;
        end
        if (ctrl_ff.load)
        begin
            nxt_ctrl.load = 1'b0;
            nxt_ctrl.halt = 1'b0;
        end
        if (wr_en)
        begin
            case (wr_sel)
                cal_clock_pkg::SEL_MIN_SEC:
                    if (ctrl_ff.halt)
                    begin
                        nxt_time.minute = wr_data[15:8];
                        nxt_time.second = wr_data[7:0];
                    end
                cal_clock_pkg::SEL_DATE_HOUR:
                    if (ctrl_ff.halt)
                    begin
                        nxt_time.date = wr_data[15:8];
                        nxt_time.hour = wr_data[7:0];
                    end
                cal_clock_pkg::SEL_YEAR_MONTH:
                    if (ctrl_ff.halt)
                    begin
                        nxt_time.year = wr_data[15:8];
                        nxt_time.month = wr_data[7:0];
                    end
                cal_clock_pkg::SEL_WDAY_CTRL:
                begin
                    if (ctrl_ff.halt)
                        nxt_time.weekday = wr_data[7:0];
                    // a write landing with a self-clear wins over the clear
                    nxt_ctrl.round = wr_data[cal_clock_pkg::ROUND_POS];
                    nxt_ctrl.halt = wr_data[cal_clock_pkg::HALT_POS];
                    nxt_ctrl.load = wr_data[cal_clock_pkg::LOAD_POS];
                end
                default:
                    nxt_time = nxt_time;
            endcase
        end
        if (!present_ff)
        begin
            nxt_time = cal_clock_pkg::TIME_RESET;
            nxt_ctrl = cal_clock_pkg::CTRL_RESET;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            time_ff <= cal_clock_pkg::TIME_RESET;
            ctrl_ff <= cal_clock_pkg::CTRL_RESET;
        end
        else
        begin
            time_ff <= nxt_time;
            ctrl_ff <= nxt_ctrl;
        end
    end

    // validity drops with the cassette and returns only after a fresh load
    logic nxt_valid;
    logic [15:0] nxt_quick;

    always_comb
    begin
        nxt_valid = valid_ff;
        if (!present_ff)
            nxt_valid = 1'b0;
        else if (ctrl_ff.load)
            nxt_valid = 1'b1;
        nxt_quick = {nxt_time.hour, nxt_time.minute};
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            valid_ff <= 1'b0;
            quick_ff <= {cal_clock_pkg::ZERO_BCD, cal_clock_pkg::ZERO_BCD};
        end
        else
        begin
            valid_ff <= nxt_valid;
            quick_ff <= nxt_quick;
        end
    end

    // word views, all taken straight from flip-flops
    assign hour_minute_quick_word = quick_ff;
    assign minute_second_word = {time_ff.minute, time_ff.second};
    assign date_hour_word = {time_ff.date, time_ff.hour};
    assign year_month_word = {time_ff.year, time_ff.month};
    assign weekday_control_word = {ctrl_ff.load, ctrl_ff.halt, ctrl_ff.round, 5'h00,
        time_ff.weekday};
    assign time_valid = valid_ff;

endmodule // cal_clock

/* File: include/cal_clock_pkg.sv */
// Purpose: shared constants and carriers for the calendar clock
// Assumes: 100 MHz system clock, all time fields two-digit BCD
// Notes: word layouts are high byte / low byte pairs of 8-bit BCD fields, except the weekday/control word whose high byte holds the control bits
package cal_clock_pkg;

    // timing
    localparam int unsigned CLOCK_HZ = 100_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = CLOCK_HZ * TICK_PERIOD_S;

    // field limits and values after reset (BCD)
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] MIN_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [7:0] WDAY_MAX = 8'h06;
    localparam logic [7:0] ZERO_BCD = 8'h00;
    localparam logic [7:0] ONE_BCD = 8'h01;
    localparam logic [7:0] HALF_MIN = 8'h30;
    localparam logic [7:0] FEB = 8'h02;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;

    // bit positions inside the weekday/control word
    localparam int unsigned ROUND_POS = 13;
    localparam int unsigned HALT_POS = 14;
    localparam int unsigned LOAD_POS = 15;

    // word selectors of the write port
    typedef enum logic [1:0] {
        SEL_MIN_SEC,
        SEL_DATE_HOUR,
        SEL_YEAR_MONTH,
        SEL_WDAY_CTRL
    } word_sel_t;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [7:0] weekday;
    } cal_time_t;

    typedef struct packed {
        logic load;
        logic halt;
        logic round;
    } cal_ctrl_t;

    localparam cal_time_t TIME_RESET = '{
        year: ZERO_BCD, month: ONE_BCD, date: ONE_BCD, hour: ZERO_BCD,
        minute: ZERO_BCD, second: ZERO_BCD, weekday: ZERO_BCD};
    localparam cal_ctrl_t CTRL_RESET = '{load: 1'b0, halt: 1'b0, round: 1'b0};

endpackage

/* File: rtl/bcd_pair_step.sv */
// Purpose: steps one two-digit BCD field by one, wrapping at a limit
// Assumes: value already lies within lo..hi
// Notes: purely combinational; carry pulses when the field wraps
`timescale 1ns/1ps
module bcd_pair_step
(
    input wire logic [7:0] value,
    input wire logic inc,
    input wire logic [7:0] lo,
    input wire logic [7:0] hi,
    output logic [7:0] nxt_value,
    output logic carry
);

    // wrap to the low limit at or above the high limit, else BCD add one
    always_comb
    begin
        nxt_value = value;
        carry = 1'b0;
        if (inc)
        begin
            if (value >= hi)
            begin
                nxt_value = lo;
                carry = 1'b1;
            end
            else if (value[3:0] >= 4'h9)
            begin
                nxt_value = {value[7:4] + 4'h1, 4'h0};
            end
            else
            begin
                nxt_value = {value[7:4], value[3:0] + 4'h1};
            end
        end
    end

endmodule // bcd_pair_step

/* File: dv/cal_clock_props.sv */
// Purpose: concurrent checks on the calendar clock ports
// Assumes: cassette pin passes two sync flops inside the block
// Notes: rounding is judged while halted so no tick interferes
`timescale 1ns/1ps
module cal_clock_props
#(
    parameter int unsigned TICK_CYCLES = 10
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic cassette_present,
    input wire logic wr_en,
    input wire cal_clock_pkg::word_sel_t wr_sel,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] hour_minute_quick_word,
    input wire logic [15:0] minute_second_word,
    input wire logic [15:0] date_hour_word,
    input wire logic [15:0] year_month_word,
    input wire logic [15:0] weekday_control_word,
    input wire logic time_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // control bits picked out of the weekday/control word
    wire logic round_bit = weekday_control_word[13];
    wire logic halt_bit = weekday_control_word[14];
    wire logic load_bit = weekday_control_word[15];
    // one step of a two-digit bcd value
    function automatic logic [7:0] bcd_up(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction
    // steps shared by several checks
    sequence fitted;
        cassette_present [*3];
    endsequence
    sequence round_req;
        round_bit && halt_bit && !wr_en;
    endsequence
    a_halt_freezes: assert property (fitted ##0 (halt_bit && !round_bit && !wr_en) |=>
        $stable(minute_second_word) && $stable(date_hour_word)) else $error("time moved while halted");
    a_load_clears: assert property (load_bit && !wr_en |=> !load_bit && !halt_bit)
        else $error("load or halt bit not cleared");
    a_load_valid: assert property (fitted ##0 load_bit |=> time_valid)
        else $error("valid not set by load");
    a_round_clears: assert property (round_req |=> !round_bit && minute_second_word[7:0] == 8'h00)
        else $error("rounding not applied or not cleared");
    a_round_low: assert property (round_req ##0 (minute_second_word[7:0] < 8'h30) |=>
        minute_second_word[15:8] == $past(minute_second_word[15:8])) else $error("minute moved");
    a_round_high: assert property (round_req ##0 (minute_second_word[7:0] >= 8'h30 &&
        minute_second_word[15:8] < 8'h59) |=> minute_second_word[15:8] ==
        bcd_up($past(minute_second_word[15:8]))) else $error("minute not advanced");
    a_quick_word: assert property (hour_minute_quick_word ==
        {date_hour_word[7:0], minute_second_word[15:8]}) else $error("quick word differs");
    a_absent_clears: assert property ((!cassette_present) [*3] |=>
        !time_valid && date_hour_word == 16'h0100) else $error("absent cassette kept time");
    a_weekday_range: assert property (weekday_control_word[7:0] <= 8'h06 &&
        weekday_control_word[12:8] == 5'h00) else $error("weekday field out of range");
    a_second_bcd: assert property (minute_second_word[3:0] <= 4'h9 &&
        minute_second_word[7:0] <= 8'h59) else $error("seconds not bcd");
endmodule // cal_clock_props
bind cal_clock cal_clock_props #(.TICK_CYCLES(TICK_CYCLES)) u_props
(
    .clock(clock), .resetn(resetn), .cassette_present(cassette_present), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .hour_minute_quick_word(hour_minute_quick_word),
    .minute_second_word(minute_second_word), .date_hour_word(date_hour_word),
    .year_month_word(year_month_word), .weekday_control_word(weekday_control_word),
    .time_valid(time_valid)
);

/* File: dv/cal_clock_tool.sv */
// Purpose: behavioural programming tool that writes clock words
// Assumes: one word per strobe, taken on the rising edge
// Notes: data bus shows the inverse of the last word between writes
`timescale 1ns/1ps
module cal_clock_tool
(
    input wire logic clock,
    output logic wr_en,
    output cal_clock_pkg::word_sel_t wr_sel,
    output logic [15:0] wr_data
);
    // idle bus at time zero
    initial
    begin
        wr_en = 1'b0;
        wr_sel = cal_clock_pkg::SEL_MIN_SEC;
        wr_data = 16'h0000;
    end
    // one word write: strobe for a single edge, then scramble the data
    task automatic put(input cal_clock_pkg::word_sel_t sel, input logic [15:0] data);
        @(posedge clock);
        wr_en <= 1'b1;
        wr_sel <= sel;
        wr_data <= data;
        @(posedge clock);
        wr_en <= 1'b0;
        wr_data <= ~data;
    endtask
endmodule // cal_clock_tool

/* File: dv/cal_clock_tb_top.sv */
// Purpose: self-checking bench for the calendar clock
// Assumes: short second tick of ten cycles
// Notes: checks are made one time unit after the edge
`timescale 1ns/1ps
module cal_clock_tb_top;
    localparam int TICKS = 10;
    localparam cal_clock_pkg::word_sel_t MS = cal_clock_pkg::SEL_MIN_SEC;
    localparam cal_clock_pkg::word_sel_t DH = cal_clock_pkg::SEL_DATE_HOUR;
    localparam cal_clock_pkg::word_sel_t YM = cal_clock_pkg::SEL_YEAR_MONTH;
    localparam cal_clock_pkg::word_sel_t WC = cal_clock_pkg::SEL_WDAY_CTRL;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cassette_present = 1'b1;
    logic wr_en;
    cal_clock_pkg::word_sel_t wr_sel;
    logic [15:0] wr_data, qw, msw, dhw, ymw, wcw;
    logic time_valid;
    int mismatches = 0;
    int compares = 0;
    // 100 MHz clock
    always #5 clock = ~clock;
    cal_clock_tool u_tool (.clock(clock), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data));
    cal_clock #(.TICK_CYCLES(TICKS)) u_dut
    (
        .clock(clock), .resetn(resetn), .cassette_present(cassette_present), .wr_en(wr_en),
        .wr_sel(wr_sel), .wr_data(wr_data), .hour_minute_quick_word(qw),
        .minute_second_word(msw), .date_hour_word(dhw), .year_month_word(ymw),
        .weekday_control_word(wcw), .time_valid(time_valid)
    );
    // shared helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic put(input cal_clock_pkg::word_sel_t sel, input logic [15:0] data);
        u_tool.put(sel, data);
        #1;
    endtask
    task automatic wait_leave(input logic [15:0] v);
        int i;
        for (i = 0; i < 4 * TICKS && msw === v; i++)
            cyc(1);
        if (i == 4 * TICKS)
        begin
            mismatches++;
            complete_run();
        end
    endtask
    // reset values, then a time write refused while running
    task automatic s_reset_refuse;
        chk(msw, 16'h0000);
        chk(dhw, 16'h0100);
        chk(ymw, 16'h0001);
        chk({15'h0000, time_valid}, 16'h0000);
        // let the cassette detect pass its sync flops so only the halt rule can refuse
        cyc(2);
        put(MS, 16'h1234);
        chk(msw, 16'h0000);
    endtask
    // halt, set last second of the century, load, watch full rollover
    task automatic s_set_rollover;
        put(WC, 16'h4000);
        put(MS, 16'h5959);
        put(DH, 16'h3123);
        put(YM, 16'h9912);
        cyc(3 * TICKS);
        chk(msw, 16'h5959);
        chk(qw, 16'h2359);
        put(WC, 16'hc006);
        cyc(1);
        chk(wcw, 16'h0006);
        chk({15'h0000, time_valid}, 16'h0001);
        wait_leave(16'h5959);
        chk(msw, 16'h0000);
        chk(dhw, 16'h0100);
        chk(ymw, 16'h0001);
        chk(wcw, 16'h0000);
        chk(qw, 16'h0000);
    endtask
    // rounding below and above the half minute, with a bcd carry
    task automatic s_round;
        put(WC, 16'h4000);
        put(MS, 16'h1229);
        put(WC, 16'h6000);
        cyc(1);
        chk(msw, 16'h1200);
        chk(wcw, 16'h4000);
        put(MS, 16'h1945);
        put(WC, 16'h6000);
        cyc(1);
        chk(msw, 16'h2000);
        chk(qw, 16'h0020);
    endtask
    // leap february: last second of the 28th rolls to the 29th, weekday steps
    task automatic s_leap;
        put(MS, 16'h5959);
        put(DH, 16'h2823);
        put(YM, 16'h2402);
        put(WC, 16'hc003);
        cyc(1);
        chk(wcw, 16'h0003);
        wait_leave(16'h5959);
        chk(msw, 16'h0000);
        chk(dhw, 16'h2900);
        chk(ymw, 16'h2402);
        chk(wcw, 16'h0004);
    endtask
    // cassette pulled: time lost, writes ignored
    task automatic s_absent;
        chk({15'h0000, time_valid}, 16'h0001);
        @(posedge clock);
        cassette_present <= 1'b0;
        cyc(4);
        chk({15'h0000, time_valid}, 16'h0000);
        chk(msw, 16'h0000);
        put(WC, 16'h4000);
        chk(wcw, 16'h0000);
        @(posedge clock);
        cassette_present <= 1'b1;
        cyc(3);
    endtask
    // main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        #1;
        s_reset_refuse();
        s_set_rollover();
        s_round();
        s_leap();
        s_absent();
        complete_run();
    end
endmodule // cal_clock_tb_top
